//--- hdl/pidss_regs.vh
// register map, field positions, reset values and timing counts of the pid supervision block
`ifndef PIDSS_REGS_VH
`define PIDSS_REGS_VH
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define PIDSS_CTRL 12'h000
`define PIDSS_SLP_TIME 12'h004
`define PIDSS_SLP_LEVEL 12'h008
`define PIDSS_WAKE_LEVEL 12'h00c
`define PIDSS_FREQ_LIM 12'h010
`define PIDSS_BIAS_GAIN 12'h014
`define PIDSS_MON_SEL 12'h018
`define PIDSS_STATUS 12'h01c
`define PIDSS_MON_VAL 12'h020
`define PIDSS_FREQ_OUT 12'h024
`define PIDSS_SW_FREQ 12'h028
// -----------------------------------------------------------------
// control fields
// -----------------------------------------------------------------
`define PIDSS_CTRL_EN 0
`define PIDSS_CTRL_SW_EN 1
`define PIDSS_CTRL_INMODE_LSB 8
`define PIDSS_CTRL_OPMODE_LSB 16
`define PIDSS_CTRL_T4FN_LSB 24
`define PIDSS_CTRL_T1FN_LSB 28
`define PIDSS_CTRL_RST 32'h0000_0000
// -----------------------------------------------------------------
// codes
// -----------------------------------------------------------------
`define PIDSS_MON_SP 8'h34
`define PIDSS_MON_PV 8'h35
`define PIDSS_MON_DEV 8'h36
`define PIDSS_IN_DEV0 8'h0a
`define PIDSS_IN_DEV1 8'h0b
`define PIDSS_IN_AUX0 8'h14
`define PIDSS_IN_AUX1 8'h15
`define PIDSS_OP_SWITCH 4'h6
`define PIDSS_FN_SLEEP_POS 8'h46
`define PIDSS_FN_SLEEP_NEG 8'haa
`define PIDSS_SLP_DISABLE 16'h270f
`define PIDSS_DEV_OFFSET 16'h03e8
`define PIDSS_PCT_FULL 16'h03e8
// -----------------------------------------------------------------
// timing: sleep time unit is 100 ms
// -----------------------------------------------------------------
`define PIDSS_CLK_HZ 25000000
`define PIDSS_TICK_MS 100
`define PIDSS_TICK_CYC (`PIDSS_CLK_HZ / 1000 * `PIDSS_TICK_MS)
`endif

//--- hdl/pidss_tick.v
// divider giving a one-cycle pulse every tick period
`include "pidss_regs.vh"
module pidss_tick #(
   parameter integer TICK_CYC = `PIDSS_TICK_CYC
) (
   input wire clk,
   input wire rst_n,
   output reg tick_q
);
   reg [31:0] cnt_q;
   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else if (cnt_q >= TICK_CYC - 1) begin
         cnt_q <= 32'h0000_0000;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h0000_0001;
         tick_q <= 1'b0;
      end
   end
endmodule // pidss_tick

//--- hdl/pidss_mon.v
// monitor value encoder: set point, measured value, deviation in 0.1 percent
`include "pidss_regs.vh"
module pidss_mon (
   input wire [7:0] mon_sel,
   input wire [7:0] in_mode,
   input wire [15:0] set_point,
   input wire [15:0] measured,
   output reg [15:0] mon_val,
   output reg meter_ok
);
   reg dev_in;
   reg [15:0] dev_enc;
   always @* begin
      dev_in = (in_mode == `PIDSS_IN_DEV0) || (in_mode == `PIDSS_IN_DEV1);
      dev_enc = `PIDSS_DEV_OFFSET + set_point - measured;
      mon_val = 16'h0000;
      meter_ok = 1'b0;
      if (mon_sel == `PIDSS_MON_SP) begin
         mon_val = dev_in ? 16'h0000 : set_point;
         meter_ok = 1'b1;
      end else if (mon_sel == `PIDSS_MON_PV) begin
         mon_val = dev_in ? 16'h0000 : measured;
         meter_ok = 1'b1;
      end else if (mon_sel == `PIDSS_MON_DEV) begin
         mon_val = dev_enc;
         meter_ok = 1'b0;
      end
   end
endmodule // pidss_mon

//--- hdl/pidss_top.v
// pid sleep, wake and supervision block with ahb-lite register slave
// How it works
// - stop output when pid frequency stays under level longer than detection time
// - wake when deviation reaches cancel setting minus 1000, in 0.1 percent
// - while asleep: sleep on, running off, pid active stays on
// - monitor codes 52, 53, 54 select set point, measured, deviation
// - deviation monitor has 1000 as zero; not for meter outputs
// - direct deviation input modes 10, 11 make set point and measured read zero
// - multi-speed or jog with pid select on stops pid control
// - operation mode 6 makes pid control invalid
// - input modes 20, 21 add terminal 1 auxiliary to terminal 2 set value
// - pid refused unless terminal 4 and terminal 1 assignments are zero
// - pid frequency bounded by bias and gain, and by maximum and minimum
// - remote up/down setting disabled while pid active
// - entering pid starts computation from 0 Hz
// - zero pid output (pid_freq_in) maps to bias, full pid output (1000) maps to gain frequency
// - start without pid until switchover frequency, then stay in pid
// - sleep reaches output terminal with function 70 or inverted with 170
// - detection time 9999 disables suspension and its indication
`include "pidss_regs.vh"
module pidss_top #(
   parameter integer TICK_CYC = `PIDSS_TICK_CYC
) (
   input wire clk,
   input wire rst_n,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hsel,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire run_cmd,
   input wire pid_select_input,
   input wire speed_select_high,
   input wire speed_select_middle,
   input wire speed_select_low,
   input wire jog_input,
   input wire panel_operation_mode,
   input wire [15:0] set_point_in,
   input wire [15:0] aux_in,
   input wire [15:0] measured_in,
   input wire [15:0] deviation_in,
   input wire [15:0] pid_freq_in,
   input wire [15:0] normal_freq_in,
   input wire [15:0] remote_freq_in,
   input wire remote_en,
   output reg sleep_indication,
   output reg running_indication,
   output reg pid_active_indication,
   output reg sleep_terminal,
   output reg pid_reset_pulse,
   output reg [15:0] freq_cmd,
   output reg [15:0] pulse_meter_output,
   output reg [15:0] analog_meter_output
);
   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   reg [31:0] ctrl_q;
   reg [15:0] slp_time_q;
   reg [15:0] slp_level_q;
   reg [15:0] wake_level_q;
   reg [31:0] lim_q;
   reg [31:0] bias_gain_q;
   reg [15:0] mon_sel_q;
   reg [15:0] sw_freq_q;
   reg [7:0] term_fn_q;
   reg dph_q;
   reg rph_q;
   reg [11:0] addr_q;
   wire [7:0] in_mode = ctrl_q[`PIDSS_CTRL_INMODE_LSB +: 8];
   wire [3:0] op_mode = ctrl_q[`PIDSS_CTRL_OPMODE_LSB +: 4];
   wire [15:0] f_max = lim_q[31:16];
   wire [15:0] f_min = lim_q[15:0];
   wire [15:0] f_gain = bias_gain_q[31:16];
   wire [15:0] f_bias = bias_gain_q[15:0];
   wire tick;
   wire [15:0] mon_val;
   wire meter_ok;
   reg [15:0] sp_eff;
   reg [15:0] cnt_q;
   reg asleep_q;
   reg pid_on_q;
   reg pid_was_q;
   reg sw_done_q;
   reg [15:0] fcmd;
   reg [15:0] pid_f;
   reg [31:0] rd;
   reg pid_ok;
   reg override;
   reg slp_en;
   reg signed [16:0] dev_pct;
   reg [31:0] span;
   // suspension only counts while pid control still holds
   wire sleeping = asleep_q && pid_on_q;
   pidss_tick #(.TICK_CYC(TICK_CYC)) u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .tick_q(tick)
   );
   always @* begin
      if (in_mode == `PIDSS_IN_AUX0 || in_mode == `PIDSS_IN_AUX1) begin
         sp_eff = set_point_in + aux_in;
      end else begin
         sp_eff = set_point_in;
      end
   end
   pidss_mon u_mon (
      .mon_sel(mon_sel_q[7:0]),
      .in_mode(in_mode),
      .set_point(sp_eff),
      .measured(measured_in),
      .mon_val(mon_val),
      .meter_ok(meter_ok)
   );
   // -----------------------------------------------------------------
   // ahb-lite slave, one wait state on reads, always okay
   // -----------------------------------------------------------------
   always @* begin
      rd = 32'h0000_0000;
      if (addr_q == `PIDSS_CTRL) begin
         rd = ctrl_q;
      end else if (addr_q == `PIDSS_SLP_TIME) begin
         rd = {16'h0000, slp_time_q};
      end else if (addr_q == `PIDSS_SLP_LEVEL) begin
         rd = {16'h0000, slp_level_q};
      end else if (addr_q == `PIDSS_WAKE_LEVEL) begin
         rd = {16'h0000, wake_level_q};
      end else if (addr_q == `PIDSS_FREQ_LIM) begin
         rd = lim_q;
      end else if (addr_q == `PIDSS_BIAS_GAIN) begin
         rd = bias_gain_q;
      end else if (addr_q == `PIDSS_MON_SEL) begin
         rd = {8'h00, term_fn_q, mon_sel_q};
      end else if (addr_q == `PIDSS_STATUS) begin
         rd = {26'h0000000, pid_ok, sw_done_q, running_indication, pid_on_q, asleep_q,
            pid_active_indication};
      end else if (addr_q == `PIDSS_MON_VAL) begin
         rd = {16'h0000, mon_val};
      end else if (addr_q == `PIDSS_FREQ_OUT) begin
         rd = {16'h0000, freq_cmd};
      end else if (addr_q == `PIDSS_SW_FREQ) begin
         rd = {16'h0000, sw_freq_q};
      end
   end
   always @(posedge clk) begin
      if (!rst_n) begin
         dph_q <= 1'b0;
         rph_q <= 1'b0;
         addr_q <= 12'h000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         ctrl_q <= `PIDSS_CTRL_RST;
         slp_time_q <= `PIDSS_SLP_DISABLE;
         slp_level_q <= 16'h0000;
         wake_level_q <= `PIDSS_DEV_OFFSET;
         lim_q <= 32'hffff_0000;
         bias_gain_q <= 32'h1770_0000;
         mon_sel_q <= 16'h0000;
         sw_freq_q <= 16'h0000;
         term_fn_q <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         rph_q <= 1'b0;
         if (hready) begin
            dph_q <= hsel && htrans[1] && hwrite;
            addr_q <= haddr[11:0];
            if (hsel && htrans[1] && !hwrite) begin
               // wait state lets read data come from a register, after any write
               rph_q <= 1'b1;
               hreadyout <= 1'b0;
            end
         end
         if (rph_q) begin
            hrdata <= rd;
         end
         if (dph_q) begin
            if (addr_q == `PIDSS_CTRL) begin
               ctrl_q <= hwdata;
            end else if (addr_q == `PIDSS_SLP_TIME) begin
               slp_time_q <= hwdata[15:0];
            end else if (addr_q == `PIDSS_SLP_LEVEL) begin
               slp_level_q <= hwdata[15:0];
            end else if (addr_q == `PIDSS_WAKE_LEVEL) begin
               wake_level_q <= hwdata[15:0];
            end else if (addr_q == `PIDSS_FREQ_LIM) begin
               lim_q <= hwdata;
            end else if (addr_q == `PIDSS_BIAS_GAIN) begin
               bias_gain_q <= hwdata;
            end else if (addr_q == `PIDSS_MON_SEL) begin
               mon_sel_q <= hwdata[15:0];
               term_fn_q <= hwdata[23:16];
            end else if (addr_q == `PIDSS_SW_FREQ) begin
               sw_freq_q <= hwdata[15:0];
            end
         end
      end
   end
   // -----------------------------------------------------------------
   // pid enable conditions
   // -----------------------------------------------------------------
   always @* begin
      override = pid_select_input && (speed_select_high || speed_select_middle ||
         speed_select_low || jog_input);
      // switchover mode invalid, terminal assignments zero
      pid_ok = ctrl_q[`PIDSS_CTRL_EN] && pid_select_input && !override &&
         (op_mode != `PIDSS_OP_SWITCH) &&
         (ctrl_q[`PIDSS_CTRL_T4FN_LSB +: 4] == 4'h0) &&
         (ctrl_q[`PIDSS_CTRL_T1FN_LSB +: 4] == 4'h0);
      slp_en = (slp_time_q != `PIDSS_SLP_DISABLE);
      // deviation in 0.1 percent against cancel level minus offset
      dev_pct = $signed({1'b0, deviation_in}) - $signed({1'b0, `PIDSS_DEV_OFFSET});
      span = (pid_freq_in >= `PIDSS_PCT_FULL) ? {16'h0000, f_gain} :
         {16'h0000, f_bias} + ((({16'h0000, f_gain} - {16'h0000, f_bias}) *
         {16'h0000, pid_freq_in}) / {16'h0000, `PIDSS_PCT_FULL});
      pid_f = span[15:0];
      // bias and gain bounds, then max and min
      if (pid_f < f_bias) begin
         pid_f = f_bias;
      end
      if (pid_f > f_gain) begin
         pid_f = f_gain;
      end
      if (pid_f > f_max) begin
         pid_f = f_max;
      end
      if (pid_f < f_min) begin
         pid_f = f_min;
      end
      if (pid_on_q) begin
         fcmd = asleep_q ? 16'h0000 : pid_f;
      end else if (remote_en) begin
         fcmd = remote_freq_in;
      end else begin
         fcmd = normal_freq_in;
      end
   end
   // -----------------------------------------------------------------
   // sleep state and outputs
   // -----------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 16'h0000;
         asleep_q <= 1'b0;
         pid_on_q <= 1'b0;
         pid_was_q <= 1'b0;
         sw_done_q <= 1'b0;
         sleep_indication <= 1'b0;
         running_indication <= 1'b0;
         pid_active_indication <= 1'b0;
         sleep_terminal <= 1'b0;
         pid_reset_pulse <= 1'b0;
         freq_cmd <= 16'h0000;
         pulse_meter_output <= 16'h0000;
         analog_meter_output <= 16'h0000;
      end else begin
         // hold off until switchover frequency, then latch
         if (!run_cmd) begin
            sw_done_q <= 1'b0;
         end else if (!ctrl_q[`PIDSS_CTRL_SW_EN] || normal_freq_in >= sw_freq_q) begin
            sw_done_q <= 1'b1;
         end
         pid_on_q <= pid_ok && run_cmd && (sw_done_q || !ctrl_q[`PIDSS_CTRL_SW_EN]);
         pid_was_q <= pid_on_q;
         pid_reset_pulse <= pid_on_q && !pid_was_q;
         if (!pid_on_q || !slp_en) begin
            cnt_q <= 16'h0000;
            asleep_q <= 1'b0;
         end else if (asleep_q) begin
            if (dev_pct >= $signed({1'b0, wake_level_q}) - $signed({1'b0, `PIDSS_DEV_OFFSET})) begin
               asleep_q <= 1'b0;
               cnt_q <= 16'h0000;
            end
         end else if (pid_f >= slp_level_q) begin
            cnt_q <= 16'h0000;
         end else if (tick) begin
            if (cnt_q >= slp_time_q) begin
               asleep_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 16'h0001;
            end
         end
         freq_cmd <= (pid_on_q && !pid_was_q) ? 16'h0000 : fcmd;
         sleep_indication <= sleeping;
         running_indication <= run_cmd && !sleeping;
         pid_active_indication <= pid_on_q;
         if (term_fn_q == `PIDSS_FN_SLEEP_POS) begin
            sleep_terminal <= sleeping;
         end else if (term_fn_q == `PIDSS_FN_SLEEP_NEG) begin
            sleep_terminal <= !sleeping;
         end else begin
            sleep_terminal <= 1'b0;
         end
         pulse_meter_output <= meter_ok ? mon_val : 16'h0000;
         analog_meter_output <= meter_ok ? mon_val : 16'h0000;
      end
   end
endmodule // pidss_top

//--- testbench/pidss_top_asserts.sv
// port-level checker for the pid supervision block, bound into its top
// ----------------------------------------
// checker
// ----------------------------------------
module pidss_checker (
   input wire clk,
   input wire rst_n,
   input wire hreadyout,
   input wire hresp,
   input wire pid_select_input,
   input wire speed_select_high,
   input wire speed_select_middle,
   input wire speed_select_low,
   input wire jog_input,
   input wire sleep_indication,
   input wire running_indication,
   input wire pid_active_indication,
   input wire pid_reset_pulse,
   input wire [15:0] freq_cmd
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   wire ovr = pid_select_input &&
      (speed_select_high || speed_select_middle || speed_select_low || jog_input);
   AST_BUS_OKAY: assert property (
      !hresp)
      else $error("bus slave response not okay");
   AST_READ_WAIT: assert property (
      !hreadyout |=> hreadyout)
      else $error("bus slave wait state longer than one cycle");
   AST_RESET_CLEAR: assert property (disable iff (1'b0)
      !rst_n |=> !sleep_indication && !running_indication && !pid_active_indication)
      else $error("indications not cleared by reset");
   AST_SLEEP_STATE: assert property (
      sleep_indication |-> !running_indication && pid_active_indication)
      else $error("sleep with running on or pid active off");
   AST_SLEEP_CAUSE: assert property (
      $rose(sleep_indication) |-> $past(pid_active_indication))
      else $error("sleep entered without pid control");
   AST_PULSE_ONE: assert property (
      pid_reset_pulse |=> !pid_reset_pulse)
      else $error("pid entry pulse longer than one cycle");
   AST_BASELINE: assert property (
      pid_reset_pulse |-> ##[0:1] freq_cmd == 16'h0000)
      else $error("pid entry does not start from zero frequency");
   AST_ENTRY_ACTIVE: assert property (
      pid_reset_pulse |-> ##[0:2] pid_active_indication)
      else $error("pid entry pulse without pid active");
   AST_OVERRIDE: assert property (
      ovr |-> ##[1:3] !pid_active_indication)
      else $error("speed or jog did not stop pid control");
   cover property ($rose(sleep_indication));
   cover property ($fell(sleep_indication));
   cover property (pid_reset_pulse);
   cover property (ovr);
endmodule // pidss_checker

bind pidss_top pidss_checker u_pidss_checker (
   .clk(clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
   .pid_select_input(pid_select_input), .speed_select_high(speed_select_high),
   .speed_select_middle(speed_select_middle), .speed_select_low(speed_select_low),
   .jog_input(jog_input), .sleep_indication(sleep_indication),
   .running_indication(running_indication), .pid_active_indication(pid_active_indication),
   .pid_reset_pulse(pid_reset_pulse), .freq_cmd(freq_cmd)
);

//--- testbench/pidss_plant.sv
// process sensor and set-point source model feeding the pid supervision block
module pidss_plant (
   input wire clk,
   input wire slow,
   input wire run_cmd,
   input wire [15:0] sp,
   input wire [15:0] pv,
   input wire [15:0] aux,
   input wire [15:0] pf,
   output logic [15:0] set_point_in = 16'h0000,
   output logic [15:0] aux_in = 16'h0000,
   output logic [15:0] measured_in = 16'h0000,
   output logic [15:0] deviation_in = 16'h03e8,
   output logic [15:0] pid_freq_in = 16'h0000,
   output logic panel_operation_mode = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div_q = 2'b00;
   always @(posedge clk) begin
      div_q <= div_q + 2'b01;
      // a slow sensor refreshes only every fourth cycle
      if (!slow || div_q == 2'b00) begin
         set_point_in <= sp;
         aux_in <= aux;
         measured_in <= pv;
         deviation_in <= 16'h03e8 + sp + aux - pv;
         pid_freq_in <= pf;
      end
      panel_operation_mode <= !run_cmd;
   end
endmodule // pidss_plant

//--- testbench/pid_sleep_and_supervision_bench.sv
// self-checking bench of the pid supervision block
`include "pidss_regs.vh"
module pid_sleep_and_supervision_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam integer BIAS = 100, GAIN = 600, FMIN = 150, FMAX = 500;
   logic clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, hsel = 1'b0, slow = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, lfsr_q = 32'h1a2a;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [3:0] ovr = 4'h0;
   logic run_cmd = 1'b0, psel = 1'b0, remote_en = 1'b0, hreadyout, hresp;
   logic [15:0] sp = 16'h0, pv = 16'h0, aux = 16'h0, pf = 16'h0, rfreq = 16'h0309;
   logic [15:0] nfreq = 16'h012c;
   logic [15:0] spi, auxi, pvi, devi, pfi, freq_cmd, pmo, amo;
   logic pmode, sleep_ind, run_ind, pid_ind, sleep_term, pid_rst;
   integer num_errors = 0, checks_done = 0, cycles = 0, i, m, c;
   integer modes[5] = '{0, 10, 11, 20, 21};
   logic [31:0] bad[3] = '{32'h0006_0001, 32'h0100_0001, 32'h1000_0001};
   always #20 clk = ~clk;
   pidss_plant u_pidss_plant (.clk(clk), .slow(slow), .run_cmd(run_cmd), .sp(sp), .pv(pv),
      .aux(aux), .pf(pf), .set_point_in(spi), .aux_in(auxi), .measured_in(pvi),
      .deviation_in(devi), .pid_freq_in(pfi), .panel_operation_mode(pmode));
   pidss_top #(.TICK_CYC(4)) u_pidss_top (.clk(clk), .rst_n(rst_n), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .run_cmd(run_cmd), .pid_select_input(psel), .speed_select_high(ovr[3]),
      .speed_select_middle(ovr[2]), .speed_select_low(ovr[1]), .jog_input(ovr[0]),
      .panel_operation_mode(pmode), .set_point_in(spi), .aux_in(auxi), .measured_in(pvi),
      .deviation_in(devi), .pid_freq_in(pfi), .normal_freq_in(nfreq),
      .remote_freq_in(rfreq), .remote_en(remote_en), .sleep_indication(sleep_ind),
      .running_indication(run_ind), .pid_active_indication(pid_ind),
      .sleep_terminal(sleep_term), .pid_reset_pulse(pid_rst), .freq_cmd(freq_cmd),
      .pulse_meter_output(pmo), .analog_meter_output(amo));
   // ----------------------------------------
   // model and helpers
   // ----------------------------------------
   function automatic integer mon_exp(input integer code, input integer mode);
      if (code == 54) return 1000 + sp + aux - pv;
      if (mode == 10 || mode == 11) return 0;
      return (code == 52) ? sp + aux : pv;
   endfunction
   function automatic integer freq_exp(input integer p);
      integer f;
      f = BIAS + (GAIN - BIAS) * p / 1000;
      f = (f < FMIN) ? FMIN : f;
      return (f > FMAX) ? FMAX : f;
   endfunction
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_edge;
      do begin
         @(posedge clk);
      end while (hreadyout !== 1'b1);
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      haddr <= {20'h00000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_edge;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_edge;
      rd = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      check(x, e);
   endtask
   task automatic close_out;
      if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out;
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      hsel <= 1'b1;
      rd_chk(`PIDSS_CTRL, 32'h0);
      rd_chk(`PIDSS_SLP_TIME, 32'h0000_270f);
      rd_chk(`PIDSS_WAKE_LEVEL, 32'h0000_03e8);
      wr(12'h02c, 32'h0000_5a5a);
      rd_chk(12'h02c, 32'h0);
      slow <= 1'b1;
      foreach (modes[m]) for (c = 52; c <= 54; c++) begin
         if (c == 54 && modes[m] >= 20) continue;
         lfsr_q = lfsr_next(lfsr_q);
         sp <= {7'h00, lfsr_q[8:0]};
         pv <= {7'h00, lfsr_q[24:16]};
         aux <= (modes[m] >= 20) ? 16'h0032 : 16'h0000;
         wr(`PIDSS_CTRL, modes[m] << `PIDSS_CTRL_INMODE_LSB);
         wr(`PIDSS_MON_SEL, c);
         repeat (10) @(posedge clk);
         rd_chk(`PIDSS_MON_VAL, mon_exp(c, modes[m]));
         check(amo, (c == 54) ? 0 : mon_exp(c, modes[m]));
         check(pmo, (c == 54) ? 0 : mon_exp(c, modes[m]));
      end
      slow <= 1'b0;
      aux <= 16'h0;
      sp <= 16'd500;
      pv <= 16'd500;
      pf <= 16'd500;
      run_cmd <= 1'b1;
      psel <= 1'b1;
      remote_en <= 1'b1;
      wr(`PIDSS_FREQ_LIM, {16'(FMAX), 16'(FMIN)});
      wr(`PIDSS_BIAS_GAIN, {16'(GAIN), 16'(BIAS)});
      wr(`PIDSS_CTRL, 32'h1);
      for (i = 0; i < 20 && pid_rst !== 1'b1; i++) @(posedge clk);
      check(pid_rst, 1'b1);
      foreach (bad[i]) begin
         wr(`PIDSS_CTRL, bad[i]);
         repeat (4) @(posedge clk);
         check(pid_ind, 1'b0);
      end
      wr(`PIDSS_CTRL, 32'h1);
      for (i = 0; i <= 1000; i += 500) begin
         pf <= 16'(i);
         repeat (5) @(posedge clk);
         check(freq_cmd, freq_exp(i));
         check({pid_ind, run_ind}, 2'b11);
      end
      for (i = 0; i < 4; i++) begin
         ovr <= 4'h1 << i;
         repeat (4) @(posedge clk);
         check(pid_ind, 1'b0);
         ovr <= 4'h0;
         repeat (4) @(posedge clk);
         check(pid_ind, 1'b1);
      end
      wr(`PIDSS_SLP_LEVEL, 32'd200);
      wr(`PIDSS_WAKE_LEVEL, 32'd1050);
      wr(`PIDSS_MON_SEL, {8'h00, `PIDSS_FN_SLEEP_POS, 16'h0034});
      pf <= 16'd100;
      repeat (40) @(posedge clk);
      check(sleep_ind, 1'b0);
      wr(`PIDSS_SLP_TIME, 32'd3);
      pf <= 16'd300;
      repeat (2) @(posedge clk);
      pf <= 16'd100;
      repeat (8) @(posedge clk);
      pf <= 16'd300;
      repeat (2) @(posedge clk);
      pf <= 16'd100;
      repeat (8) @(posedge clk);
      check(sleep_ind, 1'b0);
      for (i = 0; i < 30 && sleep_ind !== 1'b1; i++) @(posedge clk);
      check({sleep_ind, run_ind, pid_ind}, 3'b101);
      check(freq_cmd, 16'h0000);
      check(sleep_term, 1'b1);
      wr(`PIDSS_MON_SEL, {8'h00, `PIDSS_FN_SLEEP_NEG, 16'h0034});
      repeat (2) @(posedge clk);
      check(sleep_term, 1'b0);
      sp <= 16'd540;
      repeat (6) @(posedge clk);
      check(sleep_ind, 1'b1);
      sp <= 16'd550;
      repeat (4) @(posedge clk);
      check({sleep_ind, run_ind}, 2'b01);
      // hold off, then stay in pid
      pf <= 16'd500;
      run_cmd <= 1'b0;
      wr(`PIDSS_SW_FREQ, 32'd400);
      wr(`PIDSS_CTRL, 32'h3);
      run_cmd <= 1'b1;
      repeat (4) @(posedge clk);
      check(pid_ind, 1'b0);
      check(freq_cmd, rfreq);
      nfreq <= 16'd500;
      repeat (4) @(posedge clk);
      check(pid_ind, 1'b1);
      nfreq <= 16'd200;
      repeat (4) @(posedge clk);
      check(pid_ind, 1'b1);
      close_out;
   end
endmodule // pid_sleep_and_supervision_bench
